/* File: logic/dacc_top.sv */
/*
 * Two-channel 8-bit converter control: code, control and standby
 * registers behind an AHB-Lite slave, per-channel conversion and drive
 * enables, and a settling-time status per channel.
 * Assumes one system clock, chip reset on arst_n_i, and standby mode
 * levels supplied by the power controller synchronous to clk_sys_i.
 */
// The AHB-Lite register port and the register addresses were left to the implementer.
// Functional notes
// [RULE1] Per-channel 8-bit code, converted while enabled
// [RULE2] Codes cleared on reset and standby entry
// [RULE3] Control reset and standby value 0x1F
// [RULE4] Bit 7 enables channel 1
// [RULE5] Bit 6 enables channel 0
// [RULE6] Bit 5 makes conversion combined
// [RULE7] Output drive follows own enable only
// [RULE8] Reserved bits read-only, read as one
// [RULE9] Standby control 0xFE, kept in software standby
// [RULE10] Standby bit 0 keeps output in software standby
// [RULE11] Registers retained across software standby when enabled
// [RULE12] Code write restarts conversion immediately; a write of the unchanged code does not restart it
// [RULE13] Result valid after conversion time
// [RULE14] Result held until code or enable changes
// [RULE15] Enable makes pin output, else input
// [RULE16] Two independent channels
// [RULE17] Code, conversion and drive enables presented
`timescale 1ns/1ps
module dacc_top #(
    parameter int unsigned CONV_CYCLES = dacc_pkg::DACC_CONV_CYCLES
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 hsel_i,
    input  wire logic [11:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic      [31:0]          hrdata_o,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    input  wire logic                 sw_standby_i,
    input  wire logic                 hw_standby_i,
    output dacc_pkg::dacc_chan_t      ch0_o,
    output dacc_pkg::dacc_chan_t      ch1_o,
    output logic                      ch0_analog_pin_oe_o,
    output logic                      ch1_analog_pin_oe_o,
    output logic [1:0]                result_valid_o
);

    localparam int unsigned CNT_W = $clog2(CONV_CYCLES + 1);

    logic [7:0]       channel_code [2];
    logic [7:0]       converter_control;
    logic [7:0]       standby_output_control;
    logic             sw_standby_q;
    logic             wr_pend;
    logic [11:0]      wr_addr;
    logic [7:0]       next_rdata;
    logic [1:0]       conv_en;
    logic [1:0]       drive_en;
    logic [1:0]       code_wr;
    logic [1:0]       code_chg;
    logic [CNT_W-1:0] settle_cnt [2];
    logic [1:0]       conv_en_q;
    logic             ch1_output_enable;
    logic             ch0_output_enable;
    logic             combined_conversion_enable;
    logic             standby_output_enable;
    logic             stby_entry;
    logic             stby_clear;
    logic             stby_off;
    logic             addr_ok;

    function automatic logic [7:0] dacc_read(input logic [11:0] a, input logic [7:0] c0, input logic [7:0] c1,
                                             input logic [7:0] ctl, input logic [7:0] sby, input logic [1:0] rv);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            dacc_pkg::DACC_OFS_CH0_CODE:  r = c0;
            dacc_pkg::DACC_OFS_CH1_CODE:  r = c1;
            dacc_pkg::DACC_OFS_CONTROL:   r = ctl | dacc_pkg::DACC_RSV_CONTROL;
            dacc_pkg::DACC_OFS_STBY_CTRL: r = sby | dacc_pkg::DACC_RSV_STBY_CTRL;
            dacc_pkg::DACC_OFS_STATUS:    r = {6'h00, rv};
            default:                      r = 8'h00;
        endcase
        return r;
    endfunction

    assign ch1_output_enable          = converter_control[dacc_pkg::DACC_BIT_CH1_OE];
    assign ch0_output_enable          = converter_control[dacc_pkg::DACC_BIT_CH0_OE];
    assign combined_conversion_enable = converter_control[dacc_pkg::DACC_BIT_COMBINED];
    assign standby_output_enable      = standby_output_control[dacc_pkg::DACC_BIT_STBY_OE];

    // Software standby keeps state only when output stays on there
    assign stby_entry = sw_standby_i & ~sw_standby_q;
    assign stby_clear = hw_standby_i | (stby_entry & ~standby_output_enable); // [RULE11]
    assign stby_off   = hw_standby_i | (sw_standby_i & ~standby_output_enable); // [RULE10]

    // Bus: address phase captured, write applied in data phase
    assign addr_ok     = hsel_i & hready_i & ((htrans_i == dacc_pkg::DACC_HTRANS_NONSEQ) |
                                              (htrans_i == dacc_pkg::DACC_HTRANS_SEQ));
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end
        else
        begin
            wr_pend <= addr_ok & hwrite_i;
            wr_addr <= {haddr_i[11:2], 2'h0};
        end
    end

    // Read data registered at the address phase, stands in the data phase
    assign next_rdata = dacc_read({haddr_i[11:2], 2'h0}, channel_code[0], channel_code[1],
                                  converter_control, standby_output_control, result_valid_o);

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            hrdata_o <= 32'h0000_0000;
        else if (addr_ok & ~hwrite_i)
            hrdata_o <= {24'h00_0000, next_rdata}; // [RULE8]
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            sw_standby_q <= 1'b0;
        else
            sw_standby_q <= sw_standby_i;
    end

    // Two independent channels, one code register each
    for (genvar i = 0; i < 2; i++)
    begin : g_chan // [RULE16]
        assign code_wr[i] = wr_pend & (wr_addr == (i == 0 ? dacc_pkg::DACC_OFS_CH0_CODE
                                                            : dacc_pkg::DACC_OFS_CH1_CODE));
        // Rewriting the same code leaves a settled result alone
        assign code_chg[i] = code_wr[i] & (hwdata_i[7:0] != channel_code[i]);

        always_ff @(posedge clk_sys_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
                channel_code[i] <= dacc_pkg::DACC_RST_CODE; // [RULE2]
            else if (stby_clear)
                channel_code[i] <= dacc_pkg::DACC_RST_CODE; // [RULE2]
            else if (code_wr[i])
                channel_code[i] <= hwdata_i[7:0]; // [RULE1]
        end

        // Settling counter restarts on a new code or a fresh enable
        always_ff @(posedge clk_sys_i or negedge arst_n_i)
        begin
            if (!arst_n_i)
                settle_cnt[i] <= '0;
            else if (!conv_en[i])
                settle_cnt[i] <= '0;
            else if (code_chg[i] || !conv_en_q[i])
                settle_cnt[i] <= CNT_W'(CONV_CYCLES); // [RULE12]
            else if (settle_cnt[i] != '0)
                settle_cnt[i] <= settle_cnt[i] - CNT_W'(1);
        end

        // Holds until the code changes or the enable drops
        assign result_valid_o[i] = conv_en_q[i] & conv_en[i] & (settle_cnt[i] == '0); // [RULE13] [RULE14]
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            conv_en_q <= 2'b00;
        else
            conv_en_q <= conv_en;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            converter_control <= dacc_pkg::DACC_RST_CONTROL; // [RULE3]
        else if (stby_clear)
            converter_control <= dacc_pkg::DACC_RST_CONTROL; // [RULE3]
        else if (wr_pend && wr_addr == dacc_pkg::DACC_OFS_CONTROL)
            converter_control <= (hwdata_i[7:0] & ~dacc_pkg::DACC_RSV_CONTROL) | dacc_pkg::DACC_RSV_CONTROL; // [RULE8]
    end

    // Only hardware standby clears this one
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            standby_output_control <= dacc_pkg::DACC_RST_STBY_CTRL; // [RULE9]
        else if (hw_standby_i)
            standby_output_control <= dacc_pkg::DACC_RST_STBY_CTRL; // [RULE9]
        else if (wr_pend && wr_addr == dacc_pkg::DACC_OFS_STBY_CTRL)
            standby_output_control <= (hwdata_i[7:0] & ~dacc_pkg::DACC_RSV_STBY_CTRL) | dacc_pkg::DACC_RSV_STBY_CTRL;
    end

    always_comb
    begin
        conv_en[1] = ~stby_off & (ch1_output_enable | (combined_conversion_enable & ch0_output_enable)); // [RULE4] [RULE6]
        conv_en[0] = ~stby_off & (ch0_output_enable | (combined_conversion_enable & ch1_output_enable)); // [RULE5] [RULE6]
        drive_en[1] = ~stby_off & ch1_output_enable; // [RULE7]
        drive_en[0] = ~stby_off & ch0_output_enable; // [RULE7]
    end

    assign ch0_o = '{code: channel_code[0], conv_en: conv_en[0], drive_en: drive_en[0]}; // [RULE17]
    assign ch1_o = '{code: channel_code[1], conv_en: conv_en[1], drive_en: drive_en[1]}; // [RULE17]
    assign ch0_analog_pin_oe_o = drive_en[0]; // [RULE15]
    assign ch1_analog_pin_oe_o = drive_en[1]; // [RULE15]

endmodule

/* File: logic/dacc_pkg.sv */
/*
 * Package for the two-channel converter control block: register map,
 * field positions, reset values and the converter-facing carrier.
 * Assumes a 32-bit AHB-Lite slave with word-aligned registers.
 */
package dacc_pkg;

    localparam int unsigned DACC_CODE_W = 8;

    // Byte offsets within the block's window
    localparam logic [11:0] DACC_OFS_CH0_CODE  = 12'h000;
    localparam logic [11:0] DACC_OFS_CH1_CODE  = 12'h004;
    localparam logic [11:0] DACC_OFS_CONTROL   = 12'h008;
    localparam logic [11:0] DACC_OFS_STBY_CTRL = 12'h00C;
    localparam logic [11:0] DACC_OFS_STATUS    = 12'h010;

    // Field positions
    localparam int unsigned DACC_BIT_CH1_OE   = 7;
    localparam int unsigned DACC_BIT_CH0_OE   = 6;
    localparam int unsigned DACC_BIT_COMBINED = 5;
    localparam int unsigned DACC_BIT_STBY_OE  = 0;

    // Values after reset
    localparam logic [7:0] DACC_RST_CODE      = 8'h00;
    localparam logic [7:0] DACC_RST_CONTROL   = 8'h1F;
    localparam logic [7:0] DACC_RST_STBY_CTRL = 8'hFE;

    // Read-as-one masks for reserved bits
    localparam logic [7:0] DACC_RSV_CONTROL   = 8'h1F;
    localparam logic [7:0] DACC_RSV_STBY_CTRL = 8'hFE;

    // Analog settling time, longest, in ns, and its cycle count at 200 MHz
    localparam int unsigned DACC_CONV_TIME_NS = 10000;
    localparam int unsigned DACC_CLK_PERIOD_NS = 5;
    localparam int unsigned DACC_CONV_CYCLES  = DACC_CONV_TIME_NS / DACC_CLK_PERIOD_NS;

    localparam logic [1:0] DACC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] DACC_HTRANS_SEQ    = 2'h3;

    // One channel as presented to its converter
    typedef struct packed {
        logic [7:0] code;
        logic       conv_en;
        logic       drive_en;
    } dacc_chan_t;

endpackage

/* File: dv/dacc_props.sv */
/* Checker for dacc_top, bound to every instance.
   Assumes CONV_CYCLES is handed on from the instance. */
`timescale 1ns/1ps
module dacc_props #(
    parameter int unsigned CONV_CYCLES = 4
) (
    input wire logic                 clk_sys_i,
    input wire logic                 arst_n_i,
    input wire logic                 hw_standby_i,
    input wire dacc_pkg::dacc_chan_t ch0_o,
    input wire dacc_pkg::dacc_chan_t ch1_o,
    input wire logic                 ch0_analog_pin_oe_o,
    input wire logic                 ch1_analog_pin_oe_o,
    input wire logic [1:0]           result_valid_o
);
    // Slack of two cycles over the settling count
    localparam int VLAT = CONV_CYCLES + 2;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    pin_follows_a: assert property (ch0_analog_pin_oe_o == ch0_o.drive_en && ch1_analog_pin_oe_o == ch1_o.drive_en)
        else $error("pin enable differs from drive enable");
    own_conv_a: assert property ((!ch0_o.drive_en || ch0_o.conv_en) && (!ch1_o.drive_en || ch1_o.conv_en))
        else $error("driven channel not converting");
    comb_conv_a: assert property (ch0_o.conv_en || ch1_o.conv_en |-> ch0_o.drive_en || ch1_o.drive_en)
        else $error("conversion with no enable");
    reset_clear_a: assert property ($rose(arst_n_i) |-> ch0_o.code == 8'h00 && ch1_o.code == 8'h00 && !ch0_o.conv_en)
        else $error("codes not cleared by reset");
    hw_clear_a: assert property (hw_standby_i |=> ch0_o.code == 8'h00 && ch1_o.code == 8'h00 && !ch1_o.conv_en)
        else $error("codes not cleared in standby");
    settle_a: assert property ($rose(ch0_o.conv_en) |-> ##[1:VLAT] result_valid_o[0])
        else $error("result not valid after settling");
    hold_valid_a: assert property (result_valid_o[0] ##1 (ch0_o.conv_en && $stable(ch0_o.code)) |-> result_valid_o[0])
        else $error("result dropped while unchanged");
    restart_a: assert property (ch0_o.conv_en && $changed(ch0_o.code) |-> !result_valid_o[0])
        else $error("code change did not restart");
    cover property (ch1_o.conv_en && !ch1_o.drive_en);
    cover property (result_valid_o[0] && ch0_o.drive_en);
    cover property ($fell(result_valid_o[0]) && ch0_o.conv_en);
endmodule
bind dacc_top dacc_props #(.CONV_CYCLES(CONV_CYCLES)) u_dacc_props (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .hw_standby_i(hw_standby_i), .ch0_o(ch0_o), .ch1_o(ch1_o), .ch0_analog_pin_oe_o(ch0_analog_pin_oe_o),
    .ch1_analog_pin_oe_o(ch1_analog_pin_oe_o), .result_valid_o(result_valid_o));

/* File: dv/dacc_top_tb.sv */
/* Self-checking bench for dacc_top as AHB-Lite master.
   Assumes a zero-wait slave; settling count cut to 4. */
`timescale 1ns/1ps
module dacc_top_tb;
    localparam int unsigned CC = 4;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 hwrite = 1'b0;
    logic                 sw_sb = 1'b0;
    logic                 hw_sb = 1'b0;
    logic [11:0]          haddr = 12'h000;
    logic [1:0]           htrans = 2'h0;
    logic [31:0]          hwdata = 32'h0;
    logic [31:0]          hrdata;
    logic [31:0]          rd;
    logic                 hready;
    logic                 oe0;
    logic                 oe1;
    logic [1:0]           rv;
    dacc_pkg::dacc_chan_t ch0;
    dacc_pkg::dacc_chan_t ch1;
    int                   miscompares = 0;
    int                   n_compared = 0;
    int                   cyc = 0;
    logic [7:0]           v;
    always #2.5 clk = ~clk;
    dacc_top #(.CONV_CYCLES(CC)) u_dacc_top (.clk_sys_i(clk), .arst_n_i(rst_n), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .sw_standby_i(sw_sb), .hw_standby_i(hw_sb),
        .ch0_o(ch0), .ch1_o(ch1), .ch0_analog_pin_oe_o(oe0), .ch1_analog_pin_oe_o(oe1), .result_valid_o(rv));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s exp %h seen %h", nm, exp, got);
        end
    endtask
    // Entered just after a rising edge; zero-wait, but waits on hready anyway
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rck(input logic [11:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk("read", rd, {24'h0, e});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic t_regs;
        rck(12'h000, 8'h00);
        rck(12'h004, 8'h00);
        rck(12'h008, 8'h1F);
        rck(12'h00C, 8'hFE);
        bus(1'b1, 12'h000, 8'hA5);
        bus(1'b1, 12'h004, 8'h5A);
        bus(1'b1, 12'h008, 8'h00);
        bus(1'b1, 12'h00C, 8'h00);
        bus(1'b1, 12'h014, 8'hFF);
        rck(12'h000, 8'hA5);
        rck(12'h004, 8'h5A);
        rck(12'h008, 8'h1F);
        rck(12'h00C, 8'hFE);
        rck(12'h014, 8'h00);
        $display("regs done");
    endtask
    // Every enable combination; wait out settling before judging
    task automatic t_modes;
        for (int i = 0; i < 8; i++)
        begin
            v = {i[2:0], 5'h00};
            bus(1'b1, 12'h008, v);
            tick(CC + 3);
            chk("enables", {ch0.conv_en, ch1.conv_en, ch0.drive_en, ch1.drive_en, oe0, oe1},
                {v[6] | (v[5] & v[7]), v[7] | (v[5] & v[6]), v[6], v[7], v[6], v[7]});
            chk("valid", rv, {v[7] | (v[5] & v[6]), v[6] | (v[5] & v[7])});
            chk("codes", {ch1.code, ch0.code}, 32'h5AA5);
            rck(12'h008, v | 8'h1F);
        end
        $display("modes done");
    endtask
    task automatic t_settle;
        bus(1'b1, 12'h008, 8'h40);
        tick(CC + 3);
        bus(1'b1, 12'h000, 8'h33);
        #1 chk("restart", {rv[0], ch0.code}, 32'h033);
        tick(CC - 1);
        #1 chk("early", rv[0], 1'b0);
        tick(4);
        #1 chk("settled", rv[0], 1'b1);
        @(posedge clk);
        $display("settle done");
    endtask
    task automatic t_standby;
        sw_sb <= 1'b1;
        tick(2);
        chk("sw off", {ch0.conv_en, ch0.drive_en, oe0}, 3'h0);
        rck(12'h000, 8'h00);
        rck(12'h008, 8'h1F);
        sw_sb <= 1'b0;
        bus(1'b1, 12'h00C, 8'h01);
        bus(1'b1, 12'h008, 8'hC0);
        bus(1'b1, 12'h004, 8'h77);
        sw_sb <= 1'b1;
        tick(2);
        chk("sw kept", {ch0.drive_en, ch1.drive_en, ch1.code}, 32'h377);
        rck(12'h008, 8'hDF);
        rck(12'h00C, 8'hFF);
        sw_sb <= 1'b0;
        hw_sb <= 1'b1;
        tick(2);
        hw_sb <= 1'b0;
        rck(12'h00C, 8'hFE);
        rck(12'h004, 8'h00);
        $display("standby done");
    endtask
    task automatic end_of_test;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Whole run is under two hundred cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    initial
    begin
        tick(6);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_modes();
        t_settle();
        t_standby();
        end_of_test();
    end
endmodule
